// ---- logic/ccoc_chan_div.sv ----
/*
 * One clock channel: coarse phase wait, then an integer divider.
 * Assumes restart pulses one cycle whenever divider or phase is written.
 */
`timescale 1ns/1ps
`include "ccoc_defs.svh"

module ccoc_chan_div import ccoc_pkg::*; (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // Channel settings
    input wire logic [7:0] div_code,
    input wire logic [7:0] phase_code,
    input wire logic power_down,
    input wire logic restart,
    // Divided channel clock
    output logic clk_level
);

    ccoc_div_state_t s;
    ccoc_div_state_t next_s;
    logic [7:0] ratio;

    assign ratio = ccoc_div_ratio(div_code);
    assign clk_level = s.lvl;

    // Half period of ratio clocks; phase holds the start by code steps
    always_comb begin
        next_s = s;
        if (power_down || restart) begin
            next_s.cnt = 8'h00;
            next_s.lvl = 1'b0;
            next_s.hold = phase_code;
            next_s.running = 1'b0;
        end else if (!s.running) begin
            if (s.hold == 8'h00) begin
                next_s.running = 1'b1;
            end else begin
                next_s.hold = s.hold - 8'h01;
            end
        end else if (ratio == 8'h00) begin
            next_s.lvl = 1'b0; // Unlisted code: parked, not a guess at silicon
        end else if (s.cnt == ratio - 8'h01) begin
            next_s.cnt = 8'h00;
            next_s.lvl = ~s.lvl;
        end else begin
            next_s.cnt = s.cnt + 8'h01;
        end
    end

    // State register
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    chk_code_six: assert property (div_code == `CCOC_DIV_RST |-> ratio == 8'd6)
        else $error("Code 04 does not divide by six");
    chk_code_one: assert property (s.running && ratio == 8'd1 && !restart && !power_down
        |=> s.lvl != $past(s.lvl))
        else $error("Divide by one does not toggle every cycle");
    chk_phase_count: assert property (!s.running && s.hold != 8'h00 && !restart && !power_down
        |=> !s.running && s.hold == $past(s.hold) - 8'h01)
        else $error("Phase wait does not step down by one");
    chk_phase_zero: assert property ((power_down || restart) && phase_code == 8'h00
        ##1 !(power_down || restart) |=> s.running)
        else $error("Zero phase delays the start");

endmodule

// ---- logic/ccoc_defs.svh ----
/*
 * Register indices, field positions, reset values and timing figures of
 * the clock channel and clock output configuration block.
 * Assumes the includer turns an index into a byte address by times four.
 */
`ifndef CCOC_DEFS_SVH
`define CCOC_DEFS_SVH

// Channel register indices: base of channel A, stride between channels
`define CCOC_CH_BASE 8'h20
`define CCOC_CH_STRIDE 8'h10
`define CCOC_OFS_DIV 8'h00
`define CCOC_OFS_PHASE 8'h01
`define CCOC_OFS_PD 8'h02
// Output state register index of each output, E1 down to A0
`define CCOC_OUT_IDX {8'h65, 8'h64, 8'h54, 8'h45, 8'h35, 8'h34, 8'h25, 8'h24}
// Channel feeding each output, E1 down to A0
`define CCOC_OUT_CH {3'd4, 3'd4, 3'd3, 3'd2, 3'd1, 3'd1, 3'd0, 3'd0}
// Output enable register indices and their defined bits
`define CCOC_EN0_IDX 8'h74
`define CCOC_EN1_IDX 8'h75
`define CCOC_EN0_MASK 8'hDB
`define CCOC_EN1_MASK 8'h03

// Field positions
`define CCOC_PD_BIT 7
`define CCOC_FMT_BIT 4
`define CCOC_AMP_HI 3
`define CCOC_AMP_LO 2

// Reset values
`define CCOC_DIV_RST 8'h04
`define CCOC_PHASE_RST 8'h00
`define CCOC_EN_RST 8'h00

// Byte address width and bus answers
`define CCOC_AW 10
`define CCOC_RESP_OKAY 2'b00
`define CCOC_RESP_DECERR 2'b11

// Phase step; the model spends one clock per step
`define CCOC_PHASE_STEP_PS 339
`define CCOC_CLOCK_PS 25000
`define CCOC_STEP_CYCLES 1

`endif

// ---- logic/ccoc_pkg.sv ----
/*
 * Types of the clock channel and output configuration block.
 * Assumes ccoc_defs.svh is on the include path.
 */
`include "ccoc_defs.svh"

package ccoc_pkg;

    // AXI4-Lite master to slave
    typedef struct packed {
        logic [`CCOC_AW-1:0] awaddr;
        logic awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [`CCOC_AW-1:0] araddr;
        logic arvalid;
        logic rready;
    } ccoc_axi_req_t;

    // AXI4-Lite slave to master
    typedef struct packed {
        logic awready;
        logic wready;
        logic [1:0] bresp;
        logic bvalid;
        logic arready;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic rvalid;
    } ccoc_axi_rsp_t;

    // Whole state of the top module
    typedef struct packed {
        ccoc_axi_rsp_t rsp;
        logic aw_held;
        logic [7:0] aw_idx;
        logic w_held;
        logic [7:0] wbyte;
        logic wlane;
        logic [4:0][7:0] ch_div;
        logic [4:0][7:0] ch_phase;
        logic [4:0] ch_pd;
        logic [4:0] restart;
        logic [7:0] out_pd;
        logic [7:0] out_fmt;
        logic [7:0][1:0] out_amp;
        logic [7:0] en0;
        logic [7:0] en1;
        logic [7:0] pins;
    } ccoc_top_state_t;

    // Whole state of one channel divider
    typedef struct packed {
        logic [7:0] cnt;
        logic [7:0] hold;
        logic lvl;
        logic running;
    } ccoc_div_state_t;

    // Divider code to ratio; unlisted codes give 0, meaning no clock
    function automatic logic [7:0] ccoc_div_ratio(input logic [7:0] code);
        logic [7:0] r;
        r = 8'h00;
        case (code)
            8'h80: r = 8'd1;
            8'h00: r = 8'd2;
            8'h01: r = 8'd3;
            8'h02: r = 8'd4;
            8'h03: r = 8'd5;
            8'h04: r = 8'd6;
            8'h06: r = 8'd8;
            8'h43: r = 8'd10;
            8'h44: r = 8'd12;
            8'h46: r = 8'd16;
            8'h4B: r = 8'd20;
            8'h4C: r = 8'd24;
            8'h53: r = 8'd30;
            8'h4E: r = 8'd32;
            8'h54: r = 8'd36;
            8'h5B: r = 8'd40;
            8'h56: r = 8'd48;
            8'h63: r = 8'd50;
            8'h64: r = 8'd60;
            8'h5E: r = 8'd64;
            8'h5F: r = 8'd72;
            8'h66: r = 8'd80;
            8'h6E: r = 8'd96;
            8'h7B: r = 8'd100;
            8'h7C: r = 8'd120;
            8'h76: r = 8'd128;
            8'h7E: r = 8'd160;
            default: r = 8'h00;
        endcase
        return r;
    endfunction

endpackage

// ---- logic/ccoc_top.sv ----
/*
 * Clock channel and clock output configuration over AXI4-Lite.
 * Five channel dividers drive eight output pins through enable and
 * power-down gating; format and swing are handed to the drivers.
 * Assumes one clock, an AXI4-Lite master and byte address = 4 x index.
 */
`timescale 1ns/1ps
`include "ccoc_defs.svh"

module ccoc_top import ccoc_pkg::*; (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // Register bus
    input wire ccoc_axi_req_t s_axi_req,
    output ccoc_axi_rsp_t s_axi_rsp,
    // Clock outputs, E1 down to A0
    output logic [7:0] clock_output_pin,
    // Driver settings: 1 = LVPECL, swing code per output
    output logic [7:0] output_format,
    output logic [15:0] output_swing,
    output logic [7:0] output_power_down
);

    localparam logic [7:0][7:0] OUT_IDX = `CCOC_OUT_IDX;
    localparam logic [7:0][2:0] OUT_CH = `CCOC_OUT_CH;

    ccoc_top_state_t s;
    ccoc_top_state_t next_s;
    logic [4:0] chan_clk;
    logic [7:0] out_en;
    logic [7:0] ar_idx;
    logic wr_fire;
    logic rd_fire;

    // One divider per channel, so channel logic is written once
    genvar gc;
    generate
        for (gc = 0; gc < 5; gc++) begin : g_chan
            ccoc_chan_div u_div (
                .clock(clock),
                .rst_b(rst_b),
                .div_code(s.ch_div[gc]),
                .phase_code(s.ch_phase[gc]),
                .power_down(s.ch_pd[gc]),
                .restart(s.restart[gc]),
                .clk_level(chan_clk[gc])
            );
        end
    endgenerate

    // Enable bits gathered in output order, E1 down to A0
    assign out_en = {s.en1[1], s.en1[0], s.en0[0], s.en0[1],
                     s.en0[3], s.en0[4], s.en0[6], s.en0[7]};

    assign ar_idx = s_axi_req.araddr[9:2];
    assign wr_fire = s.aw_held && s.w_held && !s.rsp.bvalid;
    assign rd_fire = s_axi_req.arvalid && s.rsp.arready;

    // Outputs straight from the state register
    assign s_axi_rsp = s.rsp;
    assign clock_output_pin = s.pins;
    assign output_format = s.out_fmt;
    assign output_swing = s.out_amp;
    assign output_power_down = s.out_pd;

    // Bus handshakes, register writes and reads, output gating
    always_comb begin
        logic hit;
        logic [7:0] rd;
        hit = 1'b0;
        rd = 8'h00;
        next_s = s;
        next_s.restart = 5'b00000;

        // Address and data taken in either order; held until the write
        if (s_axi_req.awvalid && s.rsp.awready) begin
            next_s.aw_held = 1'b1;
            next_s.aw_idx = s_axi_req.awaddr[9:2];
            next_s.rsp.awready = 1'b0;
        end
        if (s_axi_req.wvalid && s.rsp.wready) begin
            next_s.w_held = 1'b1;
            next_s.wbyte = s_axi_req.wdata[7:0];
            next_s.wlane = s_axi_req.wstrb[0];
            next_s.rsp.wready = 1'b0;
        end

        // Write decode; only the low byte lane carries register data
        if (wr_fire) begin
            for (int c = 0; c < 5; c++) begin
                if (s.aw_idx == `CCOC_CH_BASE + 8'(c * `CCOC_CH_STRIDE) + `CCOC_OFS_DIV) begin
                    hit = 1'b1;
                    if (s.wlane) begin
                        next_s.ch_div[c] = s.wbyte;
                        next_s.restart[c] = 1'b1;
                    end
                end else if (s.aw_idx == `CCOC_CH_BASE + 8'(c * `CCOC_CH_STRIDE)
                             + `CCOC_OFS_PHASE) begin
                    hit = 1'b1;
                    if (s.wlane) begin
                        next_s.ch_phase[c] = s.wbyte;
                        next_s.restart[c] = 1'b1;
                    end
                end else if (s.aw_idx == `CCOC_CH_BASE + 8'(c * `CCOC_CH_STRIDE)
                             + `CCOC_OFS_PD) begin
                    hit = 1'b1;
                    if (s.wlane) begin
                        next_s.ch_pd[c] = s.wbyte[`CCOC_PD_BIT];
                    end
                end
            end
            for (int o = 0; o < 8; o++) begin
                if (s.aw_idx == OUT_IDX[o]) begin
                    hit = 1'b1;
                    if (s.wlane) begin
                        next_s.out_pd[o] = s.wbyte[`CCOC_PD_BIT];
                        next_s.out_fmt[o] = s.wbyte[`CCOC_FMT_BIT];
                        next_s.out_amp[o] = s.wbyte[`CCOC_AMP_HI:`CCOC_AMP_LO];
                    end
                end
            end
            if (s.aw_idx == `CCOC_EN0_IDX) begin
                hit = 1'b1;
                if (s.wlane) begin
                    next_s.en0 = s.wbyte & `CCOC_EN0_MASK;
                end
            end else if (s.aw_idx == `CCOC_EN1_IDX) begin
                hit = 1'b1;
                if (s.wlane) begin
                    next_s.en1 = s.wbyte & `CCOC_EN1_MASK;
                end
            end
            next_s.rsp.bvalid = 1'b1;
            next_s.rsp.bresp = hit ? `CCOC_RESP_OKAY : `CCOC_RESP_DECERR;
            next_s.aw_held = 1'b0;
            next_s.w_held = 1'b0;
        end

        // Write answer stands until taken, then both channels reopen
        if (s.rsp.bvalid && s_axi_req.bready) begin
            next_s.rsp.bvalid = 1'b0;
            next_s.rsp.awready = 1'b1;
            next_s.rsp.wready = 1'b1;
        end

        // Read decode; reserved bits read as zero
        hit = 1'b0;
        for (int c = 0; c < 5; c++) begin
            if (ar_idx == `CCOC_CH_BASE + 8'(c * `CCOC_CH_STRIDE) + `CCOC_OFS_DIV) begin
                hit = 1'b1;
                rd = s.ch_div[c];
            end else if (ar_idx == `CCOC_CH_BASE + 8'(c * `CCOC_CH_STRIDE)
                         + `CCOC_OFS_PHASE) begin
                hit = 1'b1;
                rd = s.ch_phase[c];
            end else if (ar_idx == `CCOC_CH_BASE + 8'(c * `CCOC_CH_STRIDE)
                         + `CCOC_OFS_PD) begin
                hit = 1'b1;
                rd = 8'h00;
                rd[`CCOC_PD_BIT] = s.ch_pd[c];
            end
        end
        for (int o = 0; o < 8; o++) begin
            if (ar_idx == OUT_IDX[o]) begin
                hit = 1'b1;
                rd = 8'h00;
                rd[`CCOC_PD_BIT] = s.out_pd[o];
                rd[`CCOC_FMT_BIT] = s.out_fmt[o];
                rd[`CCOC_AMP_HI:`CCOC_AMP_LO] = s.out_amp[o];
            end
        end
        if (ar_idx == `CCOC_EN0_IDX) begin
            hit = 1'b1;
            rd = s.en0;
        end else if (ar_idx == `CCOC_EN1_IDX) begin
            hit = 1'b1;
            rd = s.en1;
        end
        if (rd_fire) begin
            next_s.rsp.arready = 1'b0;
            next_s.rsp.rvalid = 1'b1;
            next_s.rsp.rdata = {24'h00_0000, rd};
            next_s.rsp.rresp = hit ? `CCOC_RESP_OKAY : `CCOC_RESP_DECERR;
        end
        if (s.rsp.rvalid && s_axi_req.rready) begin
            next_s.rsp.rvalid = 1'b0;
            next_s.rsp.arready = 1'b1;
        end

        // Pin gating: a pin runs only when every stage is up and enabled
        for (int o = 0; o < 8; o++) begin
            next_s.pins[o] = chan_clk[OUT_CH[o]]
                             & out_en[o]
                             & ~s.out_pd[o]
                             & ~s.ch_pd[OUT_CH[o]];
        end
    end

    // State register; reset values of every field
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            s <= '0;
            s.rsp.awready <= 1'b1;
            s.rsp.wready <= 1'b1;
            s.rsp.arready <= 1'b1;
            s.ch_div <= {5{`CCOC_DIV_RST}};
            s.ch_phase <= {5{`CCOC_PHASE_RST}};
            s.en0 <= `CCOC_EN_RST;
            s.en1 <= `CCOC_EN_RST;
        end else begin
            s <= next_s;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    // Write of a given byte to output A0 state
    sequence a0_write;
        wr_fire && s.wlane && s.aw_idx == OUT_IDX[0];
    endsequence

    chk_chan_down: assert property (s.ch_pd[0] |=> clock_output_pin[1:0] == 2'b00)
        else $error("Output runs while its channel is down");
    chk_out_down: assert property (s.out_pd[7] |=> !clock_output_pin[7])
        else $error("Output runs while powered down");
    chk_enable_low: assert property (!out_en[3] |=> !clock_output_pin[3])
        else $error("Disabled output not parked low");
    chk_pin_follows: assert property (out_en[5] && !s.out_pd[5] && !s.ch_pd[3]
        |=> clock_output_pin[5] == $past(chan_clk[3]))
        else $error("Enabled output D does not follow channel D");
    chk_format_write: assert property (a0_write ##1 1'b1
        |=> output_format[0] == $past(s.wbyte[`CCOC_FMT_BIT], 2))
        else $error("Format bit not applied");
    chk_swing_write: assert property (a0_write ##1 1'b1
        |=> output_swing[1:0] == $past(s.wbyte[`CCOC_AMP_HI:`CCOC_AMP_LO], 2))
        else $error("Swing code not applied");
    chk_div_restart: assert property (wr_fire && s.wlane && s.aw_idx == `CCOC_CH_BASE
        |=> s.restart[0] ##1 !s.restart[0])
        else $error("Divider write does not restart channel A once");
    chk_write_answer: assert property (wr_fire |=> s_axi_rsp.bvalid
        and (s_axi_rsp.bvalid && !s_axi_req.bready |=> s_axi_rsp.bvalid))
        else $error("Write answer missing or dropped early");

    // Read answer one cycle after the address, held until taken
    chk_read_answer: assert property (rd_fire |=> s_axi_rsp.rvalid && !s_axi_rsp.arready)
        else $error("Read answer missing after address taken");
    chk_read_holds: assert property (s_axi_rsp.rvalid && !s_axi_req.rready
        |=> s_axi_rsp.rvalid && $stable(s_axi_rsp.rdata))
        else $error("Read answer dropped or changed before taken");
    chk_read_high: assert property (s_axi_rsp.rvalid |-> s_axi_rsp.rdata[31:8] == 24'h00_0000)
        else $error("Upper read bits not zero");
    chk_write_reopen: assert property (s_axi_rsp.bvalid && s_axi_req.bready
        |=> !s_axi_rsp.bvalid && s_axi_rsp.awready && s_axi_rsp.wready)
        else $error("Write channels not reopened after the answer");
    chk_write_resp: assert property (s_axi_rsp.bvalid
        |-> s_axi_rsp.bresp == `CCOC_RESP_OKAY || s_axi_rsp.bresp == `CCOC_RESP_DECERR)
        else $error("Write answer code out of range");

    // Driver settings move only on a performed write
    chk_format_still: assert property (!wr_fire |=> $stable(output_format))
        else $error("Format changed without a write");
    chk_swing_still: assert property (!wr_fire |=> $stable(output_swing))
        else $error("Swing changed without a write");
    chk_pd_write: assert property (a0_write ##1 1'b1
        |=> output_power_down[0] == $past(s.wbyte[`CCOC_PD_BIT], 2))
        else $error("Output power-down bit not applied");
    chk_phase_restart: assert property (wr_fire && s.wlane
        && s.aw_idx == `CCOC_CH_BASE + `CCOC_OFS_PHASE |=> s.restart[0])
        else $error("Phase write does not restart channel A");

    // Undefined enable bits never hold a one
    chk_enable_mask: assert property (((s.en0 & ~`CCOC_EN0_MASK)
        | (s.en1 & ~`CCOC_EN1_MASK)) == 8'h00)
        else $error("Reserved enable bit set");

    // Channel power-down spread over its outputs, written out by hand
    logic [7:0] ch_pd_fanout;
    assign ch_pd_fanout = {{2{s.ch_pd[4]}}, s.ch_pd[3], s.ch_pd[2],
                           {2{s.ch_pd[1]}}, {2{s.ch_pd[0]}}};

    // Every gated output parked low one cycle later, whichever stage gates it
    chk_all_parked: assert property (out_en != 8'hFF
        |=> (clock_output_pin & ~$past(out_en)) == 8'h00)
        else $error("Disabled output not parked low");
    chk_all_out_down: assert property (s.out_pd != 8'h00
        |=> (clock_output_pin & $past(s.out_pd)) == 8'h00)
        else $error("Powered-down output still runs");
    chk_all_chan_down: assert property (ch_pd_fanout != 8'h00
        |=> (clock_output_pin & $past(ch_pd_fanout)) == 8'h00)
        else $error("Output runs while its channel is down");
    chk_e1_follows: assert property (out_en[7] && !s.out_pd[7] && !s.ch_pd[4]
        |=> clock_output_pin[7] == $past(chan_clk[4]))
        else $error("Enabled output E1 does not follow channel E");

endmodule

// ---- test/ccoc_load_model.sv ----
/*
 * Load model: the converter clock inputs fed by the eight output pins.
 * Assumes the pins are sampled on the block's own clock.
 */
`timescale 1ns/1ps

module ccoc_load_model (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // Observed pins and count clear
    input wire logic [7:0] pin,
    input wire logic clear,
    // Rising edges seen and last period per pin
    output logic [7:0][7:0] rises,
    output logic [7:0][9:0] period
);
    logic [7:0] last;
    logic [7:0][9:0] age;

    // A load sees only edges, so a parked pin shows no rises
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rises <= '0;
            period <= '0;
            age <= '0;
            last <= '0;
        end else begin
            last <= pin;
            for (int i = 0; i < 8; i++) begin
                age[i] <= (clear || (pin[i] && !last[i])) ? 10'h001 : age[i] + 10'h001;
                if (clear) begin
                    rises[i] <= 8'h00;
                end else if (pin[i] && !last[i]) begin
                    rises[i] <= rises[i] + 8'h01;
                    period[i] <= age[i];
                end
            end
        end
    end
endmodule

// ---- test/test_clock_channel_output_control.sv ----
/*
 * Self-checking bench of the clock channel and output configuration block.
 * Assumes a 40 MHz clock and an AXI4-Lite master driven from here.
 */
`timescale 1ns/1ps
`include "ccoc_defs.svh"

module test_clock_channel_output_control import ccoc_pkg::*;;
    logic clock, rst_b, clear;
    ccoc_axi_req_t req;
    ccoc_axi_rsp_t rsp;
    logic [7:0] pins, fmt, opd;
    logic [15:0] swing;
    logic [7:0][7:0] rises;
    logic [7:0][9:0] period;
    logic [7:0][7:0] oidx = `CCOC_OUT_IDX;
    logic [4:0][2:0] first = {3'd6, 3'd5, 3'd4, 3'd2, 3'd0};
    logic [8:0][7:0] codes = {8'h7E, 8'h43, 8'h06, 8'h04, 8'h03, 8'h02, 8'h01, 8'h00, 8'h80};
    int ratios[9] = '{1, 2, 3, 4, 5, 6, 8, 10, 160};
    int n_fail, checks;

    ccoc_top u_dut (.clock(clock), .rst_b(rst_b), .s_axi_req(req), .s_axi_rsp(rsp),
        .clock_output_pin(pins), .output_format(fmt), .output_swing(swing),
        .output_power_down(opd));
    ccoc_load_model u_load (.clock(clock), .rst_b(rst_b), .pin(pins), .clear(clear),
        .rises(rises), .period(period));

    task automatic print_verdict;
        $display("Checks %0d, errors %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic check_val(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %s: expected %h, seen %h", name, exp, got);
        end
    endtask

    task automatic check_resp(input logic [1:0] exp, input logic [1:0] got);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("Error response: expected %b, seen %b", exp, got);
        end
    endtask

    // A wait that never ends is a failure, not a hang
    task automatic give_up;
        n_fail++;
        $display("Error bus wait: expected an answer, seen none");
        print_verdict();
    endtask

    task automatic reg_write(input logic [7:0] idx, input logic [31:0] data,
        input logic [1:0] er);
        int k;
        @(posedge clock);
        req.awaddr <= {idx, 2'b00};
        req.wdata <= data;
        req.wstrb <= 4'hf;
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        req.bready <= 1'b1;
        for (k = 0; k < 100; k++) begin
            @(posedge clock);
            if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
            if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
            if (rsp.bvalid) begin
                check_resp(er, rsp.bresp);
                req.bready <= 1'b0;
                break;
            end
        end
        if (k == 100) give_up();
    endtask

    task automatic reg_read(input logic [7:0] idx, input logic [31:0] exp,
        input logic [1:0] er);
        int k;
        @(posedge clock);
        req.araddr <= {idx, 2'b00};
        req.arvalid <= 1'b1;
        req.rready <= 1'b1;
        for (k = 0; k < 100; k++) begin
            @(posedge clock);
            if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
            if (rsp.rvalid) begin
                check_val("read data", exp, rsp.rdata);
                check_resp(er, rsp.rresp);
                req.rready <= 1'b0;
                break;
            end
        end
        if (k == 100) give_up();
    endtask

    // Clear the load counts, then let the pins run
    task automatic settle(input int n);
        @(posedge clock);
        clear <= 1'b1;
        @(posedge clock);
        clear <= 1'b0;
        repeat (n) @(posedge clock);
    endtask

    // Cycles from a phase write to the first rise of pin A0
    task automatic rise_delay(input logic [7:0] ph, output int t);
        bit low;
        reg_write(8'h21, {24'h0, ph}, `CCOC_RESP_OKAY);
        t = 0;
        low = 0;
        while (t < 600) begin
            @(posedge clock);
            t++;
            if (pins[0] === 1'b0) low = 1;
            else if (low && pins[0] === 1'b1) break;
        end
        if (t == 600) give_up();
    endtask

    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    initial begin
        logic [7:0] b, v, ph;
        logic [7:0] efmt, epd;
        logic [15:0] esw;
        int c, i, t0, t;
        rst_b = 1'b0;
        clear = 1'b0;
        req = '0;
        n_fail = 0;
        checks = 0;
        void'($urandom(32'hd438));
        repeat (16) @(posedge clock);
        rst_b <= 1'b1;
        // Reset values of every channel and output
        for (c = 0; c < 5; c++) begin
            b = 8'h20 + 8'h10 * c[7:0];
            reg_read(b, 32'h04, `CCOC_RESP_OKAY);
            reg_read(b + 8'h01, 32'h00, `CCOC_RESP_OKAY);
            reg_read(b + 8'h02, 32'h00, `CCOC_RESP_OKAY);
        end
        for (i = 0; i < 8; i++) reg_read(oidx[i], 32'h00, `CCOC_RESP_OKAY);
        reg_read(8'h74, 32'h00, `CCOC_RESP_OKAY);
        reg_read(8'h75, 32'h00, `CCOC_RESP_OKAY);
        check_val("pins at reset", 32'h0, {24'h0, pins});
        check_val("format at reset", 32'h0, {24'h0, fmt});
        check_val("swing at reset", 32'h0, {16'h0, swing});
        check_val("pd at reset", 32'h0, {24'h0, opd});
        // Unmapped places answer with an error and hold nothing
        reg_write(8'h26, 32'hff, `CCOC_RESP_DECERR);
        reg_read(8'h26, 32'h00, `CCOC_RESP_DECERR);
        reg_read(8'h10, 32'h00, `CCOC_RESP_DECERR);
        // Random output states, all defined bits (9C) set on A0 as the corner
        for (i = 0; i < 8; i++) begin
            v = (i == 0) ? 8'h9C : 8'($urandom) & 8'h9C;
            efmt[i] = v[4];
            epd[i] = v[7];
            esw[2*i+:2] = v[3:2];
            reg_write(oidx[i], {24'h0, v}, `CCOC_RESP_OKAY);
            reg_read(oidx[i], {24'h0, v}, `CCOC_RESP_OKAY);
        end
        check_val("format", {24'h0, efmt}, {24'h0, fmt});
        check_val("swing", {16'h0, esw}, {16'h0, swing});
        check_val("output pd", {24'h0, epd}, {24'h0, opd});
        for (i = 0; i < 8; i++) reg_write(oidx[i], 32'h00, `CCOC_RESP_OKAY);
        reg_write(8'h74, 32'hDB, `CCOC_RESP_OKAY);
        reg_write(8'h75, 32'h03, `CCOC_RESP_OKAY);
        // Only listed divider codes are written
        for (i = 0; i < 9; i++) begin
            c = (i < 5) ? i : $urandom_range(0, 4);
            reg_write(8'h20 + 8'h10 * c[7:0], {24'h0, codes[i]}, `CCOC_RESP_OKAY);
            settle(4 * ratios[i] + 8);
            check_val("period", 2 * ratios[i], {22'h0, period[first[c]]});
        end
        // Phase delay relative to no delay, at divide by one
        reg_write(8'h20, 32'h80, `CCOC_RESP_OKAY);
        rise_delay(8'h00, t0);
        for (i = 0; i < 4; i++) begin
            ph = (i == 0) ? 8'h01 : (i == 1) ? 8'hFF : 8'($urandom);
            rise_delay(ph, t);
            check_val("phase delay", ph * `CCOC_STEP_CYCLES, t - t0);
        end
        // Enable, output power-down and channel power-down gating
        reg_write(8'h74, 32'h40, `CCOC_RESP_OKAY);
        settle(40);
        check_val("A0 disabled", 32'h0, {24'h0, rises[0]});
        check_val("A1 active", 32'h1, {31'h0, rises[1] != 8'h00});
        reg_write(8'h25, 32'h80, `CCOC_RESP_OKAY);
        settle(40);
        check_val("A1 powered down", 32'h0, {24'h0, rises[1]});
        check_val("A1 pd port", 32'h1, {31'h0, opd[1]});
        reg_write(8'h25, 32'h00, `CCOC_RESP_OKAY);
        reg_write(8'h74, 32'hDB, `CCOC_RESP_OKAY);
        reg_write(8'h22, 32'h80, `CCOC_RESP_OKAY);
        reg_read(8'h22, 32'h80, `CCOC_RESP_OKAY);
        settle(40);
        check_val("channel A down", 32'h0, {16'h0, rises[1], rises[0]});
        reg_write(8'h22, 32'h00, `CCOC_RESP_OKAY);
        // Release waits out the last phase code, up to 255 cycles
        settle(300);
        check_val("channel A up", 32'h1, {31'h0, rises[0] != 8'h00});
        print_verdict();
    end
endmodule
